// *** rtl/ehb_pkg.sv ***
// Shared constants and types of the emulation halt and breakpoint logic.
// Assumes a single clock domain and an Avalon-MM register slave.
package ehb_pkg;

  // Target address width and number of extra compare units
  localparam int EHB_ADDR_W    = 16;
  localparam int EHB_NUM_EXTRA = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_HALT_CFG   = 8'h04;
  localparam logic [7:0] OFS_START_ADDR = 8'h08;
  localparam logic [7:0] OFS_CMP_A      = 8'h0c;
  localparam logic [7:0] OFS_CMP_B      = 8'h10;
  localparam logic [7:0] OFS_EXTRA_ACT  = 8'h14;
  localparam logic [7:0] OFS_PATTERN    = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h20;
  localparam logic [7:0] OFS_TIMER      = 8'h24;
  localparam logic [7:0] OFS_BREAK_PC   = 8'h28;
  localparam logic [7:0] OFS_EXTRA_BASE = 8'h40;
  localparam logic [7:0] OFS_EXTRA_END  = 8'h60;

  // Control register bits (write), status bits (read)
  localparam int CTRL_START = 0;
  localparam int CTRL_FROM  = 1;
  localparam int CTRL_SLOW  = 2;
  localparam int CTRL_ESC   = 3;
  localparam int CTRL_SCAN  = 4;
  localparam int STAT_RUN   = 0;
  localparam int STAT_SLOW  = 1;
  localparam int STAT_SCAN  = 2;
  localparam int STAT_TRACE = 3;

  // Interrupt status bits
  localparam int IRQ_W         = 3;
  localparam int IRQ_HALT      = 0;
  localparam int IRQ_STEP      = 1;
  localparam int IRQ_SCAN_DONE = 2;

  // Halt condition field layout and reset value
  localparam int              HALT_CFG_W   = 9;
  localparam logic [8:0]      HALT_CFG_RST = 9'h000;
  localparam int              PATTERN_W    = 26;
  localparam logic [25:0]     PATTERN_RST  = 26'h0000000;

  // Base halt condition
  typedef enum logic [2:0] {
    MODE_NONE    = 3'b000,
    MODE_FOREVER = 3'b001,
    MODE_SYNC    = 3'b010,
    MODE_CMP_A   = 3'b011,
    MODE_CMP_B   = 3'b100,
    MODE_EITHER  = 3'b101
  } ehb_mode_t;

  // Qualification by the sync input
  typedef enum logic [1:0] {
    QUAL_NONE = 2'b00,
    QUAL_AND  = 2'b01,
    QUAL_OR   = 2'b10
  } ehb_qual_t;

  // Halt condition setup: bits 2:0 mode, 5:4 qual, 6 polarity, 7 trace break, 8 pattern RAM
  typedef struct packed {
    logic      ram_en;
    logic      tbr_en;
    logic      sync_high;
    ehb_qual_t qual;
    logic      spare;
    ehb_mode_t mode;
  } ehb_halt_cfg_t;

  // Pattern: bits 7:0 first byte, 15:8 second, 23:16 third, 24/25 care flags
  typedef struct packed {
    logic       care3;
    logic       care2;
    logic [7:0] byte3;
    logic [7:0] byte2;
    logic [7:0] byte1;
  } ehb_pattern_t;

  // Run controller states
  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_RUN       = 2'b01,
    ST_SLOW_STEP = 2'b10,
    ST_SLOW_WAIT = 2'b11
  } ehb_state_t;

endpackage : ehb_pkg

// *** rtl/ehb_bp_ram.sv ***
// One-bit breakpoint memory, one flag per code address.
// Assumes one writer (pattern scan) and one reader (fetch path), same clock.
module ehb_bp_ram import ehb_pkg::*; #(
  parameter int ADDR_W = EHB_ADDR_W
) (
  input  wire logic              clk_in,
  input  wire logic              ce_in,
  input  wire logic              wr_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic              wr_data_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic                   rd_data_out
);

  logic mem [2**ADDR_W];

  // Write port
  always_ff @(posedge clk_in) begin
    if (ce_in && wr_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read port
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule // ehb_bp_ram

// *** rtl/ehb_halt_logic.sv ***
// Halt condition and breakpoint logic of an in-circuit emulator.
// Assumes the target side reports first-byte fetches and step completion on CLK_IN;
// only SYNC_IN comes from a pin and is synchronised here.
//
// How it works
// - Start with address loads PC and clears cycle timer; else resume.
// - Run-forever stops only on host escape or enabled trace break.
// - Sync halt stops on sync input at level chosen by polarity bit.
// - Stop when fetched address equals compare A, compare B, or either.
// - Eight extra compare units, programmed through their own registers.
// - Either-compare also halts on any active extra compare unit match.
// - Qualified-AND halts when breakpoint and active sync coincide.
// - Qualified-OR halts when breakpoint or active sync is true, in none, compare A, compare B and either modes.
// - Compare A and B are set independently; other settings stay unchanged.
// - Halt setup is readable and writable without starting emulation.
// - Slow run steps target, checks step match after each step.
// - Step match is edge sensitive: needs a false before breaking again.
// - Pattern scan marks every code address but the last two matching up to three bytes.
// - Code breakpoints fire only on valid first-byte instruction fetches.
// - Trace records the first handler instruction after a break.
module ehb_halt_logic import ehb_pkg::*; #(
  parameter int ADDR_W    = EHB_ADDR_W,
  parameter int NUM_EXTRA = EHB_NUM_EXTRA
) (
  input  wire logic              CLK_IN,
  input  wire logic              RESETN_IN,
  input  wire logic              CE_IN,
  input  wire logic [7:0]        AVS_ADDRESS_IN,
  input  wire logic              AVS_READ_IN,
  input  wire logic              AVS_WRITE_IN,
  input  wire logic [31:0]       AVS_WRITEDATA_IN,
  output logic      [31:0]       AVS_READDATA_OUT,
  output logic                   AVS_WAITREQUEST_OUT,
  input  wire logic [ADDR_W-1:0] EXEC_ADDR_IN,
  input  wire logic              FETCH_VALID_IN,
  input  wire logic              SYNC_IN,
  input  wire logic              TRACE_BREAK_IN,
  input  wire logic              STEP_DONE_IN,
  input  wire logic              STEP_MATCH_IN,
  output logic                   CODE_RD_OUT,
  output logic      [ADDR_W-1:0] CODE_ADDR_OUT,
  input  wire logic              CODE_ACK_IN,
  input  wire logic [7:0]        CODE_DATA_IN,
  output logic                   RUN_OUT,
  output logic                   STEP_OUT,
  output logic                   PC_LOAD_OUT,
  output logic      [ADDR_W-1:0] PC_VALUE_OUT,
  output logic                   BREAK_OUT,
  output logic                   TRACE_EN_OUT,
  output logic                   IRQ_OUT
);

  // Extra compare register decode: {hit, index}
  function automatic logic [3:0] extra_sel(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFS_EXTRA_BASE;
    extra_sel = {(a >= OFS_EXTRA_BASE) && (a < OFS_EXTRA_END) && (a[1:0] == 2'b00), d[4:2]};
  endfunction

  ehb_state_t               state;
  ehb_halt_cfg_t            cfg;
  ehb_pattern_t             pat;
  logic        [ADDR_W-1:0] start_addr, cmp_a, cmp_b, break_pc;
  logic        [ADDR_W-1:0] extra_cmp [NUM_EXTRA];
  logic        [NUM_EXTRA-1:0] extra_act, extra_eq;
  logic        [IRQ_W-1:0]  irq_stat, irq_mask, irq_set;
  logic        [31:0]       cycle_timer, rd_mux;
  logic                     ack, wr_en, ctrl_wr, esc_cmd, start_cmd, scan_cmd;
  logic                     sync_ff1, sync_ff2, sync_act;
  logic                     fetch_q, bp_rd, a_hit, b_hit, extra_hit, ram_hit;
  logic                     bp_cond, tbr_hit, halt_now, step_break, prev_match, trace_tail;
  logic        [ADDR_W-1:0] addr_q;
  logic                     scan_busy;
  logic        [ADDR_W:0]   scan_cnt;
  logic        [15:0]       window;
  logic                     win_match, ram_wr;
  logic        [3:0]        esel;

  // Bus handshake: one wait cycle, answer on the second
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !(ack && CE_IN);
  assign wr_en     = AVS_WRITE_IN && ack && CE_IN;
  assign ctrl_wr   = wr_en && (AVS_ADDRESS_IN == OFS_CTRL);
  assign esc_cmd   = ctrl_wr && AVS_WRITEDATA_IN[CTRL_ESC];
  assign start_cmd = ctrl_wr && AVS_WRITEDATA_IN[CTRL_START] && (state == ST_IDLE) && !scan_busy;
  assign scan_cmd  = ctrl_wr && AVS_WRITEDATA_IN[CTRL_SCAN] && !AVS_WRITEDATA_IN[CTRL_START]
                     && (state == ST_IDLE) && !scan_busy;
  assign esel      = extra_sel(AVS_ADDRESS_IN);

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ack <= 1'b0;
    end else if (CE_IN) begin
      ack <= (AVS_READ_IN || AVS_WRITE_IN) && !ack;
    end
  end

  // Read data mux, unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (AVS_ADDRESS_IN)
      OFS_CTRL: begin
        rd_mux[STAT_RUN]   = (state == ST_RUN);
        rd_mux[STAT_SLOW]  = state[1];
        rd_mux[STAT_SCAN]  = scan_busy;
        rd_mux[STAT_TRACE] = TRACE_EN_OUT;
      end
      OFS_HALT_CFG:   rd_mux[HALT_CFG_W-1:0] = cfg;
      OFS_START_ADDR: rd_mux[ADDR_W-1:0] = start_addr;
      OFS_CMP_A:      rd_mux[ADDR_W-1:0] = cmp_a;
      OFS_CMP_B:      rd_mux[ADDR_W-1:0] = cmp_b;
      OFS_EXTRA_ACT:  rd_mux[NUM_EXTRA-1:0] = extra_act;
      OFS_PATTERN:    rd_mux[PATTERN_W-1:0] = pat;
      OFS_IRQ_STAT:   rd_mux[IRQ_W-1:0] = irq_stat;
      OFS_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_mask;
      OFS_TIMER:      rd_mux = cycle_timer;
      OFS_BREAK_PC:   rd_mux[ADDR_W-1:0] = break_pc;
      default: begin
        if (esel[3]) begin
          rd_mux[ADDR_W-1:0] = extra_cmp[esel[2:0]];
        end
      end
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      AVS_READDATA_OUT <= 32'h00000000;
    end else if (CE_IN && AVS_READ_IN && !ack) begin
      AVS_READDATA_OUT <= rd_mux;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cfg        <= ehb_halt_cfg_t'(HALT_CFG_RST);
      pat        <= ehb_pattern_t'(PATTERN_RST);
      start_addr <= '0;
      irq_mask   <= '0;
    end else if (wr_en) begin
      case (AVS_ADDRESS_IN)
        OFS_HALT_CFG:   cfg        <= ehb_halt_cfg_t'(AVS_WRITEDATA_IN[HALT_CFG_W-1:0]);
        OFS_PATTERN:    pat        <= ehb_pattern_t'(AVS_WRITEDATA_IN[PATTERN_W-1:0]);
        OFS_START_ADDR: start_addr <= AVS_WRITEDATA_IN[ADDR_W-1:0];
        OFS_IRQ_MASK:   irq_mask   <= AVS_WRITEDATA_IN[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Compare A and B, each written alone
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cmp_a <= '0;
      cmp_b <= '0;
    end else if (wr_en) begin
      if (AVS_ADDRESS_IN == OFS_CMP_A) begin
        cmp_a <= AVS_WRITEDATA_IN[ADDR_W-1:0];
      end
      if (AVS_ADDRESS_IN == OFS_CMP_B) begin
        cmp_b <= AVS_WRITEDATA_IN[ADDR_W-1:0];
      end
    end
  end

  // Extra compare units and their active flags
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      extra_act <= '0;
      for (int i = 0; i < NUM_EXTRA; i++) begin
        extra_cmp[i] <= '0;
      end
    end else if (wr_en) begin
      if (AVS_ADDRESS_IN == OFS_EXTRA_ACT) begin
        extra_act <= AVS_WRITEDATA_IN[NUM_EXTRA-1:0];
      end
      if (esel[3]) begin
        extra_cmp[esel[2:0]] <= AVS_WRITEDATA_IN[ADDR_W-1:0];
      end
    end
  end

  // Sync pin synchroniser
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync_ff1 <= 1'b0;
      sync_ff2 <= 1'b0;
    end else if (CE_IN) begin
      sync_ff1 <= SYNC_IN;
      sync_ff2 <= sync_ff1;
    end
  end

  // Active level picked by the polarity bit
  assign sync_act = (sync_ff2 == cfg.sync_high);

  // Fetch stage aligned with the breakpoint RAM read
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      fetch_q <= 1'b0;
      addr_q  <= '0;
    end else if (CE_IN) begin
      fetch_q <= FETCH_VALID_IN;
      addr_q  <= EXEC_ADDR_IN;
    end
  end

  // Every code match qualified by a first-byte fetch
  always_comb begin
    for (int i = 0; i < NUM_EXTRA; i++) begin
      extra_eq[i] = extra_act[i] && (addr_q == extra_cmp[i]);
    end
  end
  assign a_hit     = fetch_q && (addr_q == cmp_a);
  assign b_hit     = fetch_q && (addr_q == cmp_b);
  assign extra_hit = fetch_q && (|extra_eq);
  assign ram_hit   = fetch_q && cfg.ram_en && bp_rd;
  assign tbr_hit   = cfg.tbr_en && TRACE_BREAK_IN;

  always_comb begin
    case (cfg.mode)
      MODE_CMP_A:  bp_cond = a_hit;
      MODE_CMP_B:  bp_cond = b_hit;
      // Either mode adds active extra units
      MODE_EITHER: bp_cond = a_hit || b_hit || extra_hit;
      default:     bp_cond = 1'b0;
    endcase
    if (cfg.mode != MODE_FOREVER) begin
      bp_cond = bp_cond || ram_hit;
    end
  end

  always_comb begin
    // Escape and trace break stop in every mode, forever adds nothing
    halt_now = esc_cmd || tbr_hit;
    if (cfg.mode == MODE_SYNC) begin
      halt_now = halt_now || sync_act;
    end else if (cfg.mode != MODE_FOREVER) begin
      case (cfg.qual)
        QUAL_AND: halt_now = halt_now || (bp_cond && sync_act);
        QUAL_OR:  halt_now = halt_now || bp_cond || sync_act;
        default:  halt_now = halt_now || bp_cond;
      endcase
    end
    halt_now = halt_now && (state == ST_RUN);
  end

  // Step match breaks only on a rising match
  assign step_break = (state == ST_SLOW_WAIT) && STEP_DONE_IN && STEP_MATCH_IN && !prev_match;

  // Run controller: real time or slow stepping
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state <= ST_IDLE;
    end else if (CE_IN) begin
      case (state)
        ST_IDLE: begin
          if (start_cmd) begin
            state <= AVS_WRITEDATA_IN[CTRL_SLOW] ? ST_SLOW_STEP : ST_RUN;
          end
        end
        ST_RUN: begin
          if (halt_now) begin
            state <= ST_IDLE;
          end
        end
        ST_SLOW_STEP: state <= esc_cmd ? ST_IDLE : ST_SLOW_WAIT;
        ST_SLOW_WAIT: begin
          if (esc_cmd || step_break) begin
            state <= ST_IDLE;
          end else if (STEP_DONE_IN) begin
            state <= ST_SLOW_STEP;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign RUN_OUT = (state == ST_RUN);

  // Previous step match, kept across runs
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      prev_match <= 1'b0;
    end else if (CE_IN && (state == ST_SLOW_WAIT) && STEP_DONE_IN) begin
      prev_match <= STEP_MATCH_IN;
    end
  end

  // PC load and cycle timer clear on explicit start address
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PC_LOAD_OUT  <= 1'b0;
      PC_VALUE_OUT <= '0;
      cycle_timer  <= 32'h00000000;
    end else if (CE_IN) begin
      PC_LOAD_OUT <= start_cmd && AVS_WRITEDATA_IN[CTRL_FROM];
      if (start_cmd && AVS_WRITEDATA_IN[CTRL_FROM]) begin
        PC_VALUE_OUT <= start_addr;
        cycle_timer  <= 32'h00000000;
      end else if (state == ST_RUN) begin
        cycle_timer <= cycle_timer + 32'h00000001;
      end
    end
  end

  // Step pulse and break report
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      STEP_OUT  <= 1'b0;
      BREAK_OUT <= 1'b0;
      break_pc  <= '0;
    end else if (CE_IN) begin
      STEP_OUT  <= (state == ST_SLOW_STEP) && !esc_cmd;
      BREAK_OUT <= halt_now || step_break;
      if (halt_now) begin
        break_pc <= addr_q;
      end else if (step_break) begin
        break_pc <= EXEC_ADDR_IN;
      end
    end
  end

  // Trace stays on for one more fetch after a break
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      TRACE_EN_OUT <= 1'b0;
      trace_tail   <= 1'b0;
    end else if (CE_IN) begin
      if (start_cmd) begin
        TRACE_EN_OUT <= 1'b1;
        trace_tail   <= 1'b0;
      end else if (halt_now || step_break) begin
        trace_tail <= 1'b1;
      end else if (trace_tail && fetch_q) begin
        TRACE_EN_OUT <= 1'b0;
        trace_tail   <= 1'b0;
      end
    end
  end

  // Flag for address n is decided as byte n+2 arrives
  assign win_match = (window[7:0] == pat.byte1)
                  && (!pat.care2 || (window[15:8] == pat.byte2))
                  && (!pat.care3 || (CODE_DATA_IN == pat.byte3));
  assign ram_wr    = CE_IN && scan_busy && CODE_ACK_IN && (scan_cnt >= (ADDR_W+1)'(2));

  // Code memory walk, one read at a time
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      scan_busy     <= 1'b0;
      scan_cnt      <= '0;
      window        <= 16'h0000;
      CODE_RD_OUT   <= 1'b0;
      CODE_ADDR_OUT <= '0;
    end else if (CE_IN) begin
      if (scan_cmd) begin
        scan_busy     <= 1'b1;
        scan_cnt      <= '0;
        CODE_RD_OUT   <= 1'b1;
        CODE_ADDR_OUT <= '0;
      end else if (scan_busy && CODE_ACK_IN) begin
        window   <= {CODE_DATA_IN, window[15:8]};
        scan_cnt <= scan_cnt + (ADDR_W+1)'(1);
        if (scan_cnt == (ADDR_W+1)'(2**ADDR_W - 1)) begin
          scan_busy   <= 1'b0;
          CODE_RD_OUT <= 1'b0;
        end else begin
          CODE_ADDR_OUT <= CODE_ADDR_OUT + ADDR_W'(1);
        end
      end
    end
  end

  ehb_bp_ram #(
    .ADDR_W (ADDR_W)
  ) u_bp_ram (
    .clk_in      (CLK_IN),
    .ce_in       (CE_IN),
    .wr_in       (ram_wr),
    .wr_addr_in  (ADDR_W'(scan_cnt - (ADDR_W+1)'(2))),
    .wr_data_in  (win_match),
    .rd_addr_in  (EXEC_ADDR_IN),
    .rd_data_out (bp_rd)
  );

  // Interrupt sources
  assign irq_set = {(CE_IN && scan_busy && CODE_ACK_IN
                     && (scan_cnt == (ADDR_W+1)'(2**ADDR_W - 1))),
                    CE_IN && step_break, CE_IN && halt_now};

  // Sticky status, write one to clear, set wins
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_stat <= '0;
    end else if (CE_IN) begin
      if (wr_en && (AVS_ADDRESS_IN == OFS_IRQ_STAT)) begin
        irq_stat <= (irq_stat & ~AVS_WRITEDATA_IN[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
    end
  end

  assign IRQ_OUT = |(irq_stat & irq_mask);

  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  chk_from_start_timer: assert property (
    CE_IN && start_cmd && AVS_WRITEDATA_IN[CTRL_FROM]
    |=> PC_LOAD_OUT && (cycle_timer == 32'h00000000) && (PC_VALUE_OUT == $past(start_addr)))
    else $error("start with address did not load PC or clear timer");
  chk_forever_ignores: assert property (
    CE_IN && RUN_OUT && (cfg.mode == MODE_FOREVER) && !esc_cmd && !tbr_hit |=> RUN_OUT)
    else $error("run forever stopped without escape or trace break");
  chk_sync_stops: assert property (
    CE_IN && RUN_OUT && (cfg.mode == MODE_SYNC) && (sync_ff2 == cfg.sync_high)
    |=> !RUN_OUT ##0 BREAK_OUT)
    else $error("sync halt did not stop emulation");
  chk_cmp_a_stops: assert property (
    CE_IN && RUN_OUT && (cfg.mode == MODE_CMP_A) && (cfg.qual == QUAL_NONE)
    && $past(FETCH_VALID_IN) && ($past(EXEC_ADDR_IN) == cmp_a) |=> !RUN_OUT)
    else $error("compare A match did not stop emulation");
  chk_extra_stops: assert property (
    CE_IN && RUN_OUT && (cfg.mode == MODE_EITHER) && (cfg.qual == QUAL_NONE) && extra_hit
    |=> state == ST_IDLE)
    else $error("active extra unit match did not stop emulation");
  chk_and_needs_sync: assert property (
    CE_IN && RUN_OUT && (cfg.qual == QUAL_AND) && (cfg.mode != MODE_SYNC) && !sync_act
    && !esc_cmd && !tbr_hit |=> RUN_OUT)
    else $error("qualified-and stopped without sync");
  chk_or_sync_stops: assert property (
    CE_IN && RUN_OUT && (cfg.qual == QUAL_OR) && (cfg.mode != MODE_FOREVER) && sync_act
    |=> !RUN_OUT)
    else $error("qualified-or ignored sync");
  chk_step_edge: assert property (
    CE_IN && (state == ST_SLOW_WAIT) && STEP_DONE_IN && prev_match && !esc_cmd
    |=> state == ST_SLOW_STEP ##1 STEP_OUT)
    else $error("persistent step match broke again");
  chk_no_fetch_no_hit: assert property (
    CE_IN && RUN_OUT && !fetch_q && (cfg.mode != MODE_SYNC) && (cfg.qual == QUAL_NONE)
    && !esc_cmd && !tbr_hit |=> RUN_OUT)
    else $error("breakpoint fired without a valid fetch");
  chk_trace_tail: assert property (
    CE_IN && halt_now |=> TRACE_EN_OUT && trace_tail)
    else $error("trace stopped before the handler fetch");

  cov_cmp_break:  cover property (CE_IN && halt_now && bp_cond);
  cov_step_break: cover property (CE_IN && step_break);
  cov_scan_done:  cover property (irq_set[IRQ_SCAN_DONE]);

endmodule // ehb_halt_logic

// *** sim/ehb_target_model.sv ***
// Target processor stand-in: answers single steps and code reads.
// Assumes the bench steers the step-match level.
module ehb_target_model import ehb_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        step_in,
  input  wire logic        match_ctl_in,
  input  wire logic        code_rd_in,
  input  wire logic [15:0] code_addr_in,
  output logic             step_done_out,
  output logic             step_match_out,
  output logic             code_ack_out,
  output logic [7:0]       code_data_out
);
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      step_done_out <= 1'b0;
    end else begin
      step_done_out <= step_in;
    end
  end
  // Match is only valid with step done, otherwise inverted
  assign step_match_out = step_done_out ? match_ctl_in : !match_ctl_in;
  // code byte is the low address byte; toggles when idle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      code_ack_out  <= 1'b0;
      code_data_out <= 8'h00;
    end else begin
      code_ack_out  <= code_rd_in & !code_ack_out;
      code_data_out <= code_rd_in ? code_addr_in[7:0] : ~code_data_out;
    end
  end
endmodule // ehb_target_model

// *** sim/emulation_halt_breakpoint_logic_tb_top.sv ***
// Self-checking bench for the halt and breakpoint logic.
// Assumes one 200 MHz clock and the target model beside the design.
module emulation_halt_breakpoint_logic_tb_top import ehb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, fv = 1'b0, sy = 1'b0, mt = 1'b0;
  logic tb = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rdat_w;
  logic [15:0] ea = 16'h0, pcv, cad, pc_seen = 16'h0;
  logic aw, wq, stp, sd, sm, crd, cak, run, pcl, brk, tre, irq;
  logic [7:0] cdat;
  int error_cnt = 0, n_compared = 0, cyc = 0, brk_n = 0;
  // Register rows: offset, write value, expected read value
  logic [7:0] ta [7] = '{OFS_HALT_CFG, OFS_CMP_A, OFS_CMP_B, OFS_EXTRA_ACT, OFS_TIMER,
                         8'h30, 8'h44};
  logic [31:0] td [7] = '{32'h93, 32'h1234, 32'habcd, 32'hff, 32'h55, 32'hdeadbeef, 32'h321};
  logic [31:0] te [7] = '{32'h93, 32'h1234, 32'habcd, 32'hff, 32'h0, 32'h0, 32'h321};

  ehb_halt_logic i_ehb_halt_logic (.CLK_IN(clk), .RESETN_IN(rst_n), .CE_IN(1'b1),
    .AVS_ADDRESS_IN(ad), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
    .AVS_READDATA_OUT(rdat_w), .AVS_WAITREQUEST_OUT(wq), .EXEC_ADDR_IN(ea),
    .FETCH_VALID_IN(fv), .SYNC_IN(sy), .TRACE_BREAK_IN(tb), .STEP_DONE_IN(sd),
    .STEP_MATCH_IN(sm), .CODE_RD_OUT(crd), .CODE_ADDR_OUT(cad), .CODE_ACK_IN(cak),
    .CODE_DATA_IN(cdat), .RUN_OUT(run), .STEP_OUT(stp), .PC_LOAD_OUT(pcl),
    .PC_VALUE_OUT(pcv), .BREAK_OUT(brk), .TRACE_EN_OUT(tre), .IRQ_OUT(irq));
  ehb_target_model i_ehb_target_model (.clk_in(clk), .resetn_in(rst_n), .step_in(stp),
    .match_ctl_in(mt), .code_rd_in(crd), .code_addr_in(cad), .step_done_out(sd),
    .step_match_out(sm), .code_ack_out(cak), .code_data_out(cdat));

  // Clock, waitrequest seen before each rising edge, monitors and timeout
  always #2.5 clk = ~clk;
  always @(negedge clk) aw = wq;
  always @(posedge clk) begin
    cyc++;
    if (pcl === 1'b1) pc_seen <= pcv;
    if (brk === 1'b1) brk_n++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    while (aw !== 1'b0) @(posedge clk);
    if (!w) rdat = rdat_w;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  // One fetch cycle, then time for the break to land
  task fetch(input logic [15:0] a, input logic v);
    ea <= a;
    fv <= v;
    @(posedge clk);
    fv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task stop_test();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    chk(run | brk | irq | pcl, 1'b0);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) bus(1'b1, ta[i], td[i]);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ta[i], 32'h0);
      chk(rdat, te[i]);
    end
    // Start from an address, halt on compare A with qualified fetch
    bus(1'b1, OFS_START_ADDR, 32'h0100);
    bus(1'b1, OFS_HALT_CFG, 32'h3);
    bus(1'b1, OFS_CMP_A, 32'h0200);
    bus(1'b1, OFS_IRQ_MASK, 32'h3);
    bus(1'b1, OFS_CTRL, 32'h3);
    fetch(16'h0200, 1'b0);
    chk(pc_seen, 16'h0100);
    chk(run, 1'b1);
    fetch(16'h0200, 1'b1);
    chk(run, 1'b0);
    chk({irq, brk_n[0]}, 2'b11);
    chk(tre, 1'b1);
    fetch(16'h0000, 1'b1);
    chk(tre, 1'b0);
    bus(1'b0, OFS_BREAK_PC, 32'h0);
    chk(rdat, 32'h0200);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    bus(1'b1, OFS_IRQ_STAT, 32'h7);
    bus(1'b1, OFS_IRQ_MASK, 32'h3);
    chk(irq, 1'b0);
    // Either mode also halts on an active extra unit
    bus(1'b1, OFS_HALT_CFG, 32'h5);
    bus(1'b1, OFS_CTRL, 32'h1);
    chk(run, 1'b1);
    fetch(16'h0321, 1'b1);
    chk(run, 1'b0);
    // Sync halt at both polarities
    for (int p = 0; p < 2; p++) begin
      sy <= !p[0];
      bus(1'b1, OFS_HALT_CFG, 32'h2 | (p << 6));
      bus(1'b1, OFS_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      chk(run, 1'b1);
      sy <= p[0];
      repeat (6) @(posedge clk);
      chk(run, 1'b0);
    end
    // Sync qualification: AND waits for the fetch, OR stops at once
    for (int q = 1; q < 3; q++) begin
      sy <= 1'b0;
      bus(1'b1, OFS_HALT_CFG, 32'h43 | (q << 4));
      bus(1'b1, OFS_CTRL, 32'h1);
      sy <= 1'b1;
      repeat (6) @(posedge clk);
      chk(run, q == 1);
      fetch(16'h0200, 1'b1);
      chk(run, 1'b0);
    end
    // Run forever ignores sync and compare, escape stops it
    bus(1'b1, OFS_HALT_CFG, 32'hc1);
    bus(1'b1, OFS_CTRL, 32'h1);
    fetch(16'h0200, 1'b1);
    chk(run, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h8);
    chk(run, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h1);
    tb <= 1'b1;
    fetch(16'h0200, 1'b0);
    tb <= 1'b0;
    chk(run, 1'b0);
    sy <= 1'b0;
    // Slow run: break on match, no second break while it persists
    bus(1'b1, OFS_HALT_CFG, 32'h0);
    mt <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h5);
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rdat[1], 1'b1);
    bus(1'b1, OFS_IRQ_STAT, 32'h7);
    bus(1'b1, OFS_CTRL, 32'h5);
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rdat[1], 1'b0);
    mt <= 1'b0;
    repeat (10) @(posedge clk);
    mt <= 1'b1;
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rdat[1], 1'b1);
    // Pattern scan: one code address every two cycles
    bus(1'b1, OFS_PATTERN, 32'h03020100); // pattern set before the scan
    bus(1'b1, OFS_CTRL, 32'h10);
    repeat (18) @(posedge clk);
    chk(cad, 16'h0009);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk({crd, rdat[2]}, 2'b11);
    stop_test();
  end
endmodule // emulation_halt_breakpoint_logic_tb_top
